// File: hw/sar_adc_sequencer.sv
// sequencer for a 10-bit successive approximation converter, 16 channels
// assumes a sample-and-hold, dac and comparator outside; comp_in is
// synchronous to core_clk and high while the input is at or above dac
//
// Contract
// - 10-bit sar result from 16 multiplexed channels
// - programmable sample and conversion time, two sets
// - 8-bit option with fewer conversion steps
// - overrun detect flags unread result overwritten
// - overrun protect holds conversion until read
// - unused analog pins readable as digital inputs
// - single mode converts selected channel once
// - single continuous repeats channel without software
// - auto scan converts channel range once
// - scan continuous repeats range until stopped
// - injected conversion keeps sequence position and result
// - each sequence result raises event controller transfer request; injected results do not
// - calibration embedded in every conversion, after reset
// - per-pin digital input disable control
// - auto power-down when idle, wake on start
`timescale 1ns/1ns
`default_nettype none

module sar_adc_sequencer
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [adc_seq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // interrupt
  output logic irq,
  // event controller transfer
  output logic xfer_req,
  output adc_seq_pkg::result_type xfer_data,
  input wire logic xfer_ack,
  // analog front end
  output adc_seq_pkg::afe_ctrl_type afe,
  input wire logic comp_in,
  // port pins
  input wire logic [adc_seq_pkg::NUM_CH-1:0] pin_in,
  output logic [adc_seq_pkg::NUM_CH-1:0] digital_input_disable
);
  import adc_seq_pkg::*;

  logic rst_sync1_ff;
  logic rst_n_sync;
  state_type state_ff;
  logic resp_ff;
  logic [31:0] rd_val;
  logic go;
  logic wr_go;
  logic rd_go;
  logic [7:0] ctrl_ff;
  logic [31:0] timing_ff;
  logic [NUM_CH-1:0] analog_pin_digital_input_disable_ff;
  result_type conversion_result_reg_ff;
  result_type inj_result_ff;
  logic unread_ff;
  logic run_ff;
  logic inj_pend_ff;
  logic [CH_W-1:0] inj_ch_ff;
  logic cur_inj_ff;
  logic init_cal_ff;
  logic [CH_W-1:0] seq_ch_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic [RES_W-1:0] sar_ff;
  logic [3:0] bit_ff;
  logic [3:0] cal_step_ff;
  logic [IRQ_W-1:0] irq_stat_ff;
  logic [IRQ_W-1:0] irq_mask_ff;
  logic [IRQ_W-1:0] irq_ev;
  logic tick;
  logic start_wr;
  logic stop_wr;
  logic inj_wr;
  logic rd_result;
  logic store_main;
  logic store_inj;
  logic seq_end;
  logic [3:0] lsb;
  logic [CNT_W-1:0] sample_len;
  logic [CNT_W-1:0] bit_len;
  logic [CH_W-1:0] ctrl_ch_ff;
  mode_type mode;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_sync1_ff <= 1'b0;
      rst_n_sync <= 1'b0;
    end
    else
    begin
      rst_sync1_ff <= 1'b1;
      rst_n_sync <= rst_sync1_ff;
    end
  end

  // bus: one wait cycle, access lands on the edge waitrequest is low
  assign avs_waitrequest = (avs_read | avs_write) & ~resp_ff;
  assign go = (avs_read | avs_write) & resp_ff;
  assign wr_go = go & avs_write;
  assign rd_go = go & avs_read;

  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      resp_ff <= 1'b0;
    else
      resp_ff <= (avs_read | avs_write) & ~resp_ff;
  end

  assign mode = mode_type'(ctrl_ff[CTRL_MODE_LO +: 2]);
  assign start_wr = wr_go && avs_address == OFS_CTRL && avs_writedata[CTRL_START];
  assign stop_wr = wr_go && avs_address == OFS_CTRL && avs_writedata[CTRL_STOP];
  assign inj_wr = wr_go && avs_address == OFS_INJECT;
  assign rd_result = rd_go && avs_address == OFS_RESULT;

  // read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (avs_address)
      OFS_CTRL:
      begin
        rd_val[7:2] = ctrl_ff[7:2];
        rd_val[CTRL_CH_LO +: CH_W] = ctrl_ch_ff;
      end
      OFS_TIMING: rd_val = timing_ff;
      OFS_RESULT:
      begin
        rd_val[RES_W-1:0] = conversion_result_reg_ff.data;
        rd_val[RES_CH_LO +: CH_W] = conversion_result_reg_ff.channel;
        rd_val[RES_UNREAD] = unread_ff;
      end
      OFS_STATUS:
      begin
        rd_val[0] = (state_ff != ST_IDLE);
        rd_val[1] = afe.power_on;
        rd_val[2] = unread_ff;
        rd_val[3] = inj_pend_ff;
        rd_val[4] = run_ff;
        rd_val[CTRL_CH_LO +: CH_W] = seq_ch_ff;
      end
      OFS_INJECT:
      begin
        rd_val[RES_W-1:0] = inj_result_ff.data;
        rd_val[RES_CH_LO +: CH_W] = inj_result_ff.channel;
      end
      OFS_DIDIS: rd_val[NUM_CH-1:0] = analog_pin_digital_input_disable_ff;
      // disconnected pins read as zero
      OFS_PORT: rd_val[NUM_CH-1:0] = pin_in & ~analog_pin_digital_input_disable_ff;
      OFS_IRQ_STAT: rd_val[IRQ_W-1:0] = irq_stat_ff;
      OFS_IRQ_MASK: rd_val[IRQ_W-1:0] = irq_mask_ff;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      avs_readdata <= 32'h0000_0000;
    else if ((avs_read & ~resp_ff) == 1'b1)
      avs_readdata <= rd_val;
  end

  // software configuration
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      ctrl_ff <= CTRL_RST;
      ctrl_ch_ff <= '0;
      timing_ff <= TIMING_RST;
      analog_pin_digital_input_disable_ff <= '0;
      irq_mask_ff <= '0;
    end
    else if (wr_go)
    begin
      unique case (avs_address)
        OFS_CTRL:
        begin
          ctrl_ff <= {avs_writedata[7:2], 2'b00};
          ctrl_ch_ff <= avs_writedata[CTRL_CH_LO +: CH_W];
        end
        OFS_TIMING: timing_ff <= avs_writedata;
        OFS_DIDIS: analog_pin_digital_input_disable_ff <= avs_writedata[NUM_CH-1:0];
        OFS_IRQ_MASK: irq_mask_ff <= avs_writedata[IRQ_W-1:0];
        default:
        begin
        end
      endcase
    end
  end

  assign digital_input_disable = analog_pin_digital_input_disable_ff;

  // two timing sets, chosen by the control byte
  assign sample_len = ctrl_ff[CTRL_TSEL] ? timing_ff[23:16] : timing_ff[7:0];
  assign bit_len = ctrl_ff[CTRL_TSEL] ? timing_ff[31:24] : timing_ff[15:8];
  assign lsb = ctrl_ff[CTRL_RES8] ? LSB_8 : LSB_10;

  // phase divider: one-cycle tick when the loaded length has elapsed
  assign tick = (cnt_ff == '0);

  assign store_main = (state_ff == ST_STORE) && !cur_inj_ff && !init_cal_ff;
  assign store_inj = (state_ff == ST_STORE) && cur_inj_ff && !init_cal_ff;
  // last step of a non-continuous sequence
  assign seq_end = (mode == MODE_SINGLE) || (mode == MODE_SCAN && seq_ch_ff == '0);

  // conversion state machine
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      state_ff <= ST_IDLE;
      cnt_ff <= '0;
      cur_inj_ff <= 1'b0;
      sar_ff <= '0;
      bit_ff <= MSB;
    end
    else
    begin
      unique case (state_ff)
        // converter stays unpowered here
        ST_IDLE:
        begin
          if (run_ff || inj_pend_ff || init_cal_ff)
          begin
            state_ff <= ST_WAKE;
            cnt_ff <= WAKE_CYCLES;
          end
        end
        ST_WAKE:
        begin
          if (tick)
            state_ff <= ST_HOLD;
          else
            cnt_ff <= cnt_ff - 1'b1;
        end
        ST_HOLD:
        begin
          if (init_cal_ff)
          begin
            state_ff <= ST_CAL;
            cnt_ff <= CAL_CYCLES;
          end
          else if (inj_pend_ff)
          begin
            // injection goes in between sequence steps
            state_ff <= ST_SAMPLE;
            cur_inj_ff <= 1'b1;
            cnt_ff <= sample_len;
          end
          else if (!run_ff)
            state_ff <= ST_IDLE;
          else if (!(ctrl_ff[CTRL_PROTECT] && unread_ff))
          begin
            state_ff <= ST_SAMPLE;
            cur_inj_ff <= 1'b0;
            cnt_ff <= sample_len;
          end
        end
        ST_SAMPLE:
        begin
          if (tick)
          begin
            state_ff <= ST_CONV;
            cnt_ff <= bit_len;
            bit_ff <= MSB;
            sar_ff <= RES_W'(1) << MSB;
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        end
        ST_CONV:
        begin
          if (tick)
          begin
            // keep the trial bit while the input stays at or above it
            sar_ff[bit_ff] <= comp_in;
            if (bit_ff == lsb)
            begin
              state_ff <= ST_CAL;
              cnt_ff <= CAL_CYCLES;
            end
            else
            begin
              sar_ff[bit_ff - 1'b1] <= 1'b1;
              bit_ff <= bit_ff - 1'b1;
              cnt_ff <= bit_len;
            end
          end
          else
            cnt_ff <= cnt_ff - 1'b1;
        end
        // fixed slot in every conversion so the rate never changes
        ST_CAL:
        begin
          if (tick)
            state_ff <= ST_STORE;
          else
            cnt_ff <= cnt_ff - 1'b1;
        end
        ST_STORE:
        begin
          state_ff <= ST_HOLD;
          cur_inj_ff <= 1'b0;
        end
      endcase
    end
  end

  // calibration counter and first calibration after reset
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      init_cal_ff <= 1'b1;
      cal_step_ff <= '0;
    end
    else if (state_ff == ST_STORE)
    begin
      init_cal_ff <= 1'b0;
      cal_step_ff <= cal_step_ff + 1'b1;
    end
  end

  // sequence position: injected conversions leave it untouched
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      run_ff <= 1'b0;
      seq_ch_ff <= '0;
    end
    else if (start_wr)
    begin
      run_ff <= 1'b1;
      seq_ch_ff <= avs_writedata[CTRL_CH_LO +: CH_W];
    end
    else if (stop_wr)
      run_ff <= 1'b0;
    else if (store_main)
    begin
      if (seq_end)
        run_ff <= 1'b0;
      else if (mode == MODE_SCAN || mode == MODE_SCAN_CONT)
      begin
        // scan walks down to channel 0; continuous scan then reloads
        if (seq_ch_ff == '0)
          seq_ch_ff <= ctrl_ch_ff;
        else
          seq_ch_ff <= seq_ch_ff - 1'b1;
      end
    end
  end

  // injection request
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      inj_pend_ff <= 1'b0;
      inj_ch_ff <= '0;
    end
    else if (inj_wr)
    begin
      inj_pend_ff <= 1'b1;
      inj_ch_ff <= avs_writedata[CH_W-1:0];
    end
    else if (state_ff == ST_HOLD && !init_cal_ff && inj_pend_ff)
      inj_pend_ff <= 1'b0;
  end

  // result registers
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
    begin
      conversion_result_reg_ff <= '0;
      inj_result_ff <= '0;
    end
    else if (store_main)
    begin
      conversion_result_reg_ff.data <= sar_ff;
      conversion_result_reg_ff.channel <= seq_ch_ff;
    end
    else if (store_inj)
    begin
      inj_result_ff.data <= sar_ff;
      inj_result_ff.channel <= inj_ch_ff;
    end
  end

  // unread flag: a new result wins over a read in the same cycle
  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      unread_ff <= 1'b0;
    else if (store_main)
      unread_ff <= 1'b1;
    else if (rd_result || xfer_ack)
      unread_ff <= 1'b0;
  end

  assign xfer_req = unread_ff;
  assign xfer_data = conversion_result_reg_ff;

  // interrupt events
  assign irq_ev[IRQ_DONE] = store_main;
  assign irq_ev[IRQ_OVR] = store_main && unread_ff && !(rd_result || xfer_ack);
  assign irq_ev[IRQ_INJ] = store_inj;

  always_ff @(posedge core_clk or negedge rst_n_sync)
  begin
    if (!rst_n_sync)
      irq_stat_ff <= '0;
    else if (wr_go && avs_address == OFS_IRQ_STAT)
      irq_stat_ff <= (irq_stat_ff & ~avs_writedata[IRQ_W-1:0]) | irq_ev;
    else
      irq_stat_ff <= irq_stat_ff | irq_ev;
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  // front end drive
  always_comb
  begin
    afe.power_on = (state_ff != ST_IDLE);
    afe.track = (state_ff == ST_SAMPLE);
    afe.cal = (state_ff == ST_CAL);
    afe.cal_step = cal_step_ff;
    afe.channel = cur_inj_ff ? inj_ch_ff : seq_ch_ff;
    afe.dac = sar_ff;
  end

endmodule

`default_nettype wire

// File: pkg/adc_seq_pkg.sv
// constants, register map and carrier types for the sar converter sequencer
// assumes a 32-bit avalon-mm slave port with byte addressing
package adc_seq_pkg;

  // sizes
  localparam int RES_W = 10;
  localparam int CH_W = 4;
  localparam int NUM_CH = 16;
  localparam int ADDR_W = 6;
  localparam int CNT_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_TIMING = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_RESULT = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_INJECT = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_DIDIS = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_PORT = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 6'h20;

  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_STOP = 1;
  localparam int CTRL_MODE_LO = 2;
  localparam int CTRL_RES8 = 4;
  localparam int CTRL_PROTECT = 5;
  localparam int CTRL_TSEL = 6;
  localparam int CTRL_CH_LO = 8;
  // result register fields
  localparam int RES_CH_LO = 12;
  localparam int RES_UNREAD = 16;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_OVR = 1;
  localparam int IRQ_INJ = 2;
  localparam int IRQ_W = 3;

  // reset values
  localparam logic [31:0] TIMING_RST = 32'h0F07_0301;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // fixed phase counter loads, one core clock cycle short of the phase length, and sar bit positions
  localparam logic [CNT_W-1:0] WAKE_CYCLES = 8'h07;
  localparam logic [CNT_W-1:0] CAL_CYCLES = 8'h03;
  localparam logic [3:0] LSB_10 = 4'h0;
  localparam logic [3:0] LSB_8 = 4'h2;
  localparam logic [3:0] MSB = 4'h9;

  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_SINGLE_CONT = 2'h1,
    MODE_SCAN = 2'h2,
    MODE_SCAN_CONT = 2'h3
  } mode_type;

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_WAKE = 7'h02,
    ST_HOLD = 7'h04,
    ST_SAMPLE = 7'h08,
    ST_CONV = 7'h10,
    ST_CAL = 7'h20,
    ST_STORE = 7'h40
  } state_type;

  // drive bundle towards the analog front end
  typedef struct packed {
    logic power_on;
    logic track;
    logic cal;
    logic [3:0] cal_step;
    logic [CH_W-1:0] channel;
    logic [RES_W-1:0] dac;
  } afe_ctrl_type;

  typedef struct packed {
    logic [CH_W-1:0] channel;
    logic [RES_W-1:0] data;
  } result_type;

endpackage

// File: tb/sar_adc_sequencer_sva.sv
// checker for the sar converter sequencer, bound to its top module
// sees the top ports only; control fields are shadowed from bus writes
`timescale 1ns/1ns
`default_nettype none

module sar_adc_sequencer_sva
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register bus
  input wire logic [adc_seq_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  // converter side
  input wire logic xfer_req,
  input wire logic xfer_ack,
  input wire adc_seq_pkg::result_type xfer_data,
  input wire adc_seq_pkg::afe_ctrl_type afe,
  input wire logic [adc_seq_pkg::NUM_CH-1:0] digital_input_disable
);
  import adc_seq_pkg::*;
  logic wr_ok;
  logic ctrl_wr;
  logic res8_ff;
  logic scan_ff;
  logic [CH_W-1:0] ch_ff;

  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  assign wr_ok = avs_write && !avs_waitrequest;
  assign ctrl_wr = wr_ok && avs_address == OFS_CTRL;

  // only a start write loads the setup a result is judged against
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      res8_ff <= 1'b0;
      scan_ff <= 1'b0;
      ch_ff <= '0;
    end
    else if (ctrl_wr && avs_writedata[CTRL_START])
    begin
      res8_ff <= avs_writedata[CTRL_RES8];
      scan_ff <= avs_writedata[CTRL_MODE_LO+1];
      ch_ff <= avs_writedata[CTRL_CH_LO+:CH_W];
    end
  end

  property p_didis_load;
    wr_ok && avs_address == OFS_DIDIS |=> digital_input_disable == $past(avs_writedata[15:0]);
  endproperty
  a_didis_load: assert property (p_didis_load) else $error("pin disable not loaded");

  property p_didis_hold;
    !(wr_ok && avs_address == OFS_DIDIS) |=> $stable(digital_input_disable);
  endproperty
  a_didis_hold: assert property (p_didis_hold) else $error("pin disable changed");

  property p_cal_before;
    $rose(xfer_req) |-> $past(afe.cal) || $past(afe.cal, 2) || $past(afe.cal, 3);
  endproperty
  a_cal_before: assert property (p_cal_before) else $error("result without calibration");

  // the step index moves on once per finished calibration slot
  property p_cal_step;
    $fell(afe.cal) |=> afe.cal_step == 4'($past(afe.cal_step) + 4'h1);
  endproperty
  a_cal_step: assert property (p_cal_step) else $error("calibration step not advanced");

  property p_ack_clears;
    xfer_req && xfer_ack && !afe.power_on |=> !xfer_req;
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("request kept after ack");

  property p_start_wakes;
    ctrl_wr && avs_writedata[CTRL_START] |-> ##[1:3] afe.power_on;
  endproperty
  a_start_wakes: assert property (p_start_wakes) else $error("start did not wake");

  property p_track_powered;
    afe.track |-> afe.power_on;
  endproperty
  a_track_powered: assert property (p_track_powered) else $error("tracking unpowered");

  property p_res8;
    $rose(xfer_req) && res8_ff |-> xfer_data.data[1:0] == 2'h0;
  endproperty
  a_res8: assert property (p_res8) else $error("low bits set in 8-bit result");

  property p_single_ch;
    $rose(xfer_req) && !scan_ff |-> xfer_data.channel == ch_ff;
  endproperty
  a_single_ch: assert property (p_single_ch) else $error("wrong channel converted");

  c_ack: cover property (xfer_req && xfer_ack);
  c_power_down: cover property ($fell(afe.power_on));
  c_res8: cover property ($rose(xfer_req) && res8_ff);
endmodule

bind sar_adc_sequencer sar_adc_sequencer_sva u_sar_adc_sequencer_sva (
  .core_clk(core_clk), .rst_n(rst_n), .avs_address(avs_address), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest), .xfer_req(xfer_req),
  .xfer_ack(xfer_ack), .xfer_data(xfer_data), .afe(afe),
  .digital_input_disable(digital_input_disable));

`default_nettype wire

// File: tb/afe_model.sv
// behavioural sample-and-hold and comparator front end
// levels are loaded by the bench; comparator answer is registered
`timescale 1ns/1ns
`default_nettype none

module afe_model
(
  // clock
  input wire logic core_clk,
  // drive from the sequencer
  input wire adc_seq_pkg::afe_ctrl_type afe,
  output var logic comp_in
);
  import adc_seq_pkg::*;
  logic [RES_W-1:0] level [NUM_CH];
  logic [RES_W-1:0] held;

  task automatic set_level(input logic [CH_W-1:0] ch, input logic [RES_W-1:0] v);
    level[ch] = v;
  endtask

  initial
  begin
    comp_in = 1'b0;
    held = '0;
    foreach (level[i])
      level[i] = '0;
  end

  // unpowered comparator gives no answer: toggle so nothing settles by luck
  always @(posedge core_clk)
  begin
    if (afe.track)
      held <= level[afe.channel];
    if (!afe.power_on)
      comp_in <= ~comp_in;
    else
      comp_in <= held >= afe.dac;
  end
endmodule

`default_nettype wire

// File: tb/sar_adc_sequencer_test.sv
// self-checking bench for the sar converter sequencer
// drives the avalon-mm port and event acks; front end is afe_model
`timescale 1ns/1ns
`default_nettype none

module sar_adc_sequencer_test;
  import adc_seq_pkg::*;
  logic core_clk;
  logic rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic irq;
  logic xfer_req;
  result_type xfer_data;
  logic xfer_ack;
  afe_ctrl_type afe;
  logic comp_in;
  logic [NUM_CH-1:0] pin_in;
  logic [NUM_CH-1:0] digital_input_disable;
  logic [RES_W-1:0] lvl [NUM_CH];
  logic [31:0] rd;
  int miscompares;
  int num_checks;
  int c10;
  int c8;
  int cb;

  sar_adc_sequencer u_sar_adc_sequencer (.core_clk(core_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq), .xfer_req(xfer_req),
    .xfer_data(xfer_data), .xfer_ack(xfer_ack), .afe(afe), .comp_in(comp_in),
    .pin_in(pin_in), .digital_input_disable(digital_input_disable));
  afe_model u_afe_model (.core_clk(core_clk), .afe(afe), .comp_in(comp_in));

  always #20 core_clk = ~core_clk;

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // entered just after a rising edge; read data lands in rd
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // waitrequest settles by mid-cycle and holds up to the next rising edge
    do
    begin
      @(negedge core_clk);
    end
    while (avs_waitrequest !== 1'b0);
    @(posedge core_clk);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask

  // no local limit: the watchdog ends a hang
  task automatic wait_req(output int n);
    n = 0;
    while (xfer_req !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
    end
    @(posedge core_clk);
  endtask

  task automatic wait_idle;
    repeat (4) @(posedge core_clk);
    while (afe.power_on !== 1'b0)
      @(negedge core_clk);
    @(posedge core_clk);
  endtask

  task automatic test_pins;
    pin_in <= 16'hA5C3;
    bus(1'b1, OFS_DIDIS, 32'h0000_00FF);
    check({16'h0, digital_input_disable}, 32'h0000_00FF);
    bus(1'b0, OFS_DIDIS, 32'h0);
    check(rd, 32'h0000_00FF);
    bus(1'b0, OFS_PORT, 32'h0);
    check(rd, 32'h0000_A500);
    bus(1'b1, 6'h3C, 32'hFFFF_FFFF);
    bus(1'b0, 6'h3C, 32'h0);
    check(rd, 32'h0);
  endtask

  task automatic test_timing;
    bus(1'b0, OFS_TIMING, 32'h0);
    check(rd, TIMING_RST);
    bus(1'b1, OFS_CTRL, 32'h0000_0601);
    wait_req(c10);
    check({18'h0, xfer_data}, {18'h0, 4'h6, lvl[6]});
    bus(1'b0, OFS_RESULT, 32'h0);
    check(rd, {15'h0, 1'b1, 4'h6, 2'h0, lvl[6]});
    wait_idle;
    repeat (60) @(posedge core_clk);
    check({30'h0, xfer_req, afe.power_on}, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0000_0611);
    wait_req(c8);
    check({18'h0, xfer_data}, {18'h0, 4'h6, lvl[6] & 10'h3FC});
    xfer_ack <= 1'b1;
    @(posedge core_clk);
    xfer_ack <= 1'b0;
    @(negedge core_clk);
    check({31'h0, xfer_req}, 32'h0);
    wait_idle;
    check(c10 - c8, 8);
    // set B: sample 8 against 2 cycles, bit 16 against 4 cycles
    bus(1'b1, OFS_CTRL, 32'h0000_0641);
    wait_req(cb);
    check(cb - c10, 126);
    // start bit is a strobe and never reads back
    bus(1'b0, OFS_CTRL, 32'h0);
    check(rd, 32'h0000_0640);
    bus(1'b0, OFS_RESULT, 32'h0);
    wait_idle;
  endtask

  task automatic test_scan;
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    bus(1'b1, OFS_CTRL, 32'h0000_0209);
    wait_idle;
    check({18'h0, xfer_data}, {18'h0, 4'h0, lvl[0]});
    check({31'h0, irq}, 32'h0);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    check(rd, 32'h3);
    bus(1'b1, OFS_IRQ_MASK, 32'h2);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_IRQ_STAT, 32'h3);
    check({31'h0, irq}, 32'h0);
    bus(1'b0, OFS_RESULT, 32'h0);
  endtask

  task automatic test_protect;
    int n;
    bus(1'b1, OFS_CTRL, 32'h0000_0129);
    wait_req(n);
    repeat (150) @(posedge core_clk);
    check({18'h0, xfer_data}, {18'h0, 4'h1, lvl[1]});
    // parked in hold: busy, powered, unread, running, next channel 0
    bus(1'b0, OFS_STATUS, 32'h0);
    check(rd, 32'h0000_0017);
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    check(rd & 32'h2, 32'h0);
    bus(1'b0, OFS_RESULT, 32'h0);
    wait_req(n);
    check({18'h0, xfer_data}, {18'h0, 4'h0, lvl[0]});
    bus(1'b0, OFS_RESULT, 32'h0);
    wait_idle;
  endtask

  // three sequence results with one injection after the first
  task automatic test_cont(input logic [31:0] ctl, input logic [3:0] ch, input logic scan);
    int n;
    logic [3:0] e;
    bus(1'b1, OFS_IRQ_STAT, 32'h7);
    bus(1'b1, OFS_CTRL, ctl);
    for (int i = 0; i < 3; i++)
    begin
      wait_req(n);
      e = scan ? ch - 4'(i % (ch + 1)) : ch;
      check({18'h0, xfer_data}, {18'h0, e, lvl[e]});
      bus(1'b0, OFS_RESULT, 32'h0);
      if (i == 0)
        bus(1'b1, OFS_INJECT, 32'h7);
    end
    bus(1'b0, OFS_INJECT, 32'h0);
    check(rd & 32'hF3FF, {16'h0, 4'h7, 2'h0, lvl[7]});
    bus(1'b0, OFS_IRQ_STAT, 32'h0);
    check(rd & 32'h4, 32'h4);
    bus(1'b1, OFS_CTRL, (ctl & 32'hFFFF_FFFE) | 32'h2);
    wait_idle;
    bus(1'b0, OFS_RESULT, 32'h0);
    check({31'h0, afe.power_on}, 32'h0);
  endtask

  initial
  begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    finish_test;
  end

  initial
  begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    xfer_ack = 1'b0;
    pin_in = '0;
    miscompares = 0;
    num_checks = 0;
    for (int i = 0; i < NUM_CH; i++)
      lvl[i] = 10'(i * 61 + 7);
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < NUM_CH; i++)
      u_afe_model.set_level(4'(i), lvl[i]);
    repeat (3) @(posedge core_clk);
    // power-up calibration must finish and power down by itself
    wait_idle;
    test_pins;
    test_timing;
    test_scan;
    test_protect;
    test_cont(32'h0000_0405, 4'h4, 1'b0);
    test_cont(32'h0000_010D, 4'h1, 1'b1);
    finish_test;
  end
endmodule

`default_nettype wire
